// *** hdl/mox_regs.vh ***
// Opcode encodings and field positions for the move/OR execution block.
// Assumes a 14-bit instruction word delivered by the fetch logic.
`ifndef MOX_REGS_VH
`define MOX_REGS_VH
`define MOX_INSTR_W 14
`define MOX_ADDR_W 7
`define MOX_DATA_W 8
`define MOX_FILE_DEPTH 128
`define MOX_DEST_BIT 7
`define MOX_OP_OR_FILE 6'h04
`define MOX_OP_MOVE_FILE 6'h08
`define MOX_OP_LIT_HI 4'hc
`define MOX_OP_STORE 7'h01
`define MOX_NOP_WORD 14'h0000
`define MOX_ACC_RESET 8'h00
`define MOX_ZERO_RESET 1'h0
`define MOX_DONE_RESET 1'h0
`define MOX_PEEK_RESET 8'h00
`define MOX_OP6_LO 8
`define MOX_OP7_LO 7
`define MOX_OP4_LO 10
`endif

// *** hdl/mox_exec.v ***
// Executes OR-with-file, move-file, store-accumulator, literal load and no-op.
// Assumes one instruction word per clock, presented with INSTR_VALID from
// same-clock fetch logic; other opcodes leave accumulator, flag and file unchanged but still pulse DONE.
// Function
// - OR accumulator with file, zero flag
// - Move file to accumulator or back
// - Move file updates zero flag
// - Store accumulator to file, flags kept
// - Load literal into accumulator, flags kept
`timescale 1ns/10ps
`default_nettype none
`include "mox_regs.vh"

// Flags an all-zero word; shared by the OR and move paths.
module mox_is_zero #(
  parameter WIDTH = `MOX_DATA_W
) (
  input wire [WIDTH-1:0] word, // Word under test
  output wire is_zero // High when every bit is clear
);
  assign is_zero = ~|word;
endmodule // mox_is_zero

// Splits a word into one strobe per supported operation and its operand fields.
// Any other word, the no-op included, raises no strobe and so leaves accumulator, flag and file unchanged.
module mox_decode (
  input wire valid, // Word present this cycle
  input wire [`MOX_INSTR_W-1:0] instr, // Instruction word
  output reg is_or, // OR accumulator with file
  output reg is_move, // Move file register
  output reg is_store, // Store accumulator to file
  output reg is_lit, // Load literal to accumulator
  output reg dest_file, // Destination select, 1 is file
  output reg [`MOX_ADDR_W-1:0] addr, // File address field
  output reg [`MOX_DATA_W-1:0] lit_value // Immediate field
);
  always @* begin
    is_or = 1'h0;
    is_move = 1'h0;
    is_store = 1'h0;
    is_lit = 1'h0;
    dest_file = instr[`MOX_DEST_BIT];
    addr = instr[`MOX_ADDR_W-1:0];
    lit_value = instr[`MOX_DATA_W-1:0];
    if (valid) begin
      if (instr[`MOX_INSTR_W-1:`MOX_OP6_LO] == `MOX_OP_OR_FILE) begin
        is_or = 1'h1;
      end else if (instr[`MOX_INSTR_W-1:`MOX_OP6_LO] == `MOX_OP_MOVE_FILE) begin
        is_move = 1'h1;
      end else if (instr[`MOX_INSTR_W-1:`MOX_OP7_LO] == `MOX_OP_STORE) begin
        is_store = 1'h1;
      end else if (instr[`MOX_INSTR_W-1:`MOX_OP4_LO] == `MOX_OP_LIT_HI) begin
        is_lit = 1'h1;
      end
    end
  end
endmodule // mox_decode

// File register space: operand read, one write, and an observe port.
// No reset, so it maps onto plain memory; contents are unknown until written.
module mox_file (
  input wire clk, // Core clock
  input wire we, // Write strobe
  input wire [`MOX_ADDR_W-1:0] addr, // Operand and write address
  input wire [`MOX_DATA_W-1:0] wdata, // Write data
  output wire [`MOX_DATA_W-1:0] rdata, // Operand read, combinational
  input wire [`MOX_ADDR_W-1:0] peek_addr, // Observe address
  output wire [`MOX_DATA_W-1:0] peek_rdata // Observe read, combinational
);
  reg [`MOX_DATA_W-1:0] mem [0:`MOX_FILE_DEPTH-1];

  assign rdata = mem[addr];
  assign peek_rdata = mem[peek_addr];

  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end
endmodule // mox_file

// Forms the next accumulator, zero flag and file write for the decoded word.
// At most one strobe is high, so the branches never compete.
module mox_alu (
  input wire is_or, // OR accumulator with file
  input wire is_move, // Move file register
  input wire is_store, // Store accumulator to file
  input wire is_lit, // Load literal to accumulator
  input wire dest_file, // Destination select, 1 is file
  input wire [`MOX_DATA_W-1:0] acc, // Present accumulator
  input wire zero_now, // Present zero flag
  input wire [`MOX_DATA_W-1:0] fval, // Addressed file register
  input wire [`MOX_DATA_W-1:0] lit_value, // Immediate field
  output reg [`MOX_DATA_W-1:0] next_acc, // Accumulator after this word
  output reg next_zero, // Zero flag after this word
  output reg file_we, // File write strobe
  output reg [`MOX_DATA_W-1:0] file_wdata // File write data
);
  wire [`MOX_DATA_W-1:0] or_result;
  wire or_zero;
  wire fval_zero;

  assign or_result = acc | fval;

  mox_is_zero #(
    .WIDTH(`MOX_DATA_W)
  ) u_or_zero (
    .word(or_result),
    .is_zero(or_zero)
  );

  mox_is_zero #(
    .WIDTH(`MOX_DATA_W)
  ) u_fval_zero (
    .word(fval),
    .is_zero(fval_zero)
  );

  always @* begin
    next_acc = acc;
    next_zero = zero_now;
    file_we = 1'h0;
    file_wdata = fval;
    if (is_or) begin
      next_zero = or_zero;
      if (dest_file) begin
        file_we = 1'h1;
        file_wdata = or_result;
      end else begin
        next_acc = or_result;
      end
    end else if (is_move) begin
      if (dest_file) begin
        file_we = 1'h1;
        file_wdata = fval;
      end else begin
        next_acc = fval;
      end
      next_zero = fval_zero;
    end else if (is_store) begin
      file_we = 1'h1;
      file_wdata = acc;
    end else if (is_lit) begin
      next_acc = lit_value;
    end
  end
endmodule // mox_alu

module mox_exec (
  input wire CLK, // 100 MHz core clock
  input wire RSTN, // Asynchronous reset, active low
  input wire INSTR_VALID, // Instruction word present this cycle
  input wire [`MOX_INSTR_W-1:0] INSTR, // Instruction word
  input wire [`MOX_ADDR_W-1:0] PEEK_ADDR, // File address to observe
  output reg [`MOX_DATA_W-1:0] ACC, // Working accumulator
  output reg ZERO_FLAG, // Zero status flag
  output reg [`MOX_DATA_W-1:0] PEEK_DATA, // File contents at PEEK_ADDR
  output reg DONE // Pulse: instruction retired
);
  wire is_or;
  wire is_move;
  wire is_store;
  wire is_lit;
  wire dest_file;
  wire [`MOX_ADDR_W-1:0] addr;
  wire [`MOX_DATA_W-1:0] lit_value;
  wire [`MOX_DATA_W-1:0] fval;
  wire [`MOX_DATA_W-1:0] peek_rdata;
  wire [`MOX_DATA_W-1:0] next_acc;
  wire next_zero;
  wire file_we;
  wire [`MOX_DATA_W-1:0] file_wdata;

  mox_decode u_mox_decode (
    .valid(INSTR_VALID),
    .instr(INSTR),
    .is_or(is_or),
    .is_move(is_move),
    .is_store(is_store),
    .is_lit(is_lit),
    .dest_file(dest_file),
    .addr(addr),
    .lit_value(lit_value)
  );

  // Write and operand read share one address, so each word sees the value left
  // by the word before it; back-to-back words need no stall.
  mox_file u_mox_file (
    .clk(CLK),
    .we(file_we),
    .addr(addr),
    .wdata(file_wdata),
    .rdata(fval),
    .peek_addr(PEEK_ADDR),
    .peek_rdata(peek_rdata)
  );

  mox_alu u_mox_alu (
    .is_or(is_or),
    .is_move(is_move),
    .is_store(is_store),
    .is_lit(is_lit),
    .dest_file(dest_file),
    .acc(ACC),
    .zero_now(ZERO_FLAG),
    .fval(fval),
    .lit_value(lit_value),
    .next_acc(next_acc),
    .next_zero(next_zero),
    .file_we(file_we),
    .file_wdata(file_wdata)
  );

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ACC <= `MOX_ACC_RESET;
      ZERO_FLAG <= `MOX_ZERO_RESET;
      DONE <= `MOX_DONE_RESET;
      PEEK_DATA <= `MOX_PEEK_RESET;
    end else begin
      ACC <= next_acc;
      ZERO_FLAG <= next_zero;
      DONE <= INSTR_VALID;
      PEEK_DATA <= peek_rdata;
    end
  end
endmodule // mox_exec
`default_nettype wire

// *** test/mox_exec_assertions.sv ***
// Port checker for mox_exec, bound to its top.
// Assumes one core clock and the active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module mox_chk (
  input wire logic CLK, // Core clock
  input wire logic RSTN, // Reset, active low
  input wire logic INSTR_VALID, // Word present
  input wire logic [13:0] INSTR, // Instruction word
  input wire logic [6:0] PEEK_ADDR, // Observe address
  input wire logic [7:0] ACC, // Accumulator
  input wire logic ZERO_FLAG, // Zero flag
  input wire logic [7:0] PEEK_DATA, // Observed file value
  input wire logic DONE // Retire pulse
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  wire v = INSTR_VALID;
  wire [5:0] op = INSTR[13:8];
  wire is_store = (INSTR[13:7] == 7'h01);
  wire is_lit = (INSTR[13:10] == 4'hc);
  sequence s_store_seen;
    v && is_store && (INSTR[6:0] == PEEK_ADDR);
  endsequence
  sequence s_peek_held;
    !v && $stable(PEEK_ADDR);
  endsequence
  a_lit_load: assert property (v && is_lit |=> ACC == $past(INSTR[7:0]))
    else $error("literal not loaded");
  a_keep_flag: assert property (v && (is_lit || is_store)
    |=> $stable(ZERO_FLAG)) else $error("flag moved");
  a_acc_zero: assert property (v && (op == 6'h04 || op == 6'h08) && !INSTR[7]
    |=> ZERO_FLAG == (ACC == 8'h00)) else $error("zero flag wrong");
  a_move_back: assert property (v && op == 6'h08 && INSTR[7] |=> $stable(ACC))
    else $error("acc moved");
  a_store_acc: assert property (v && is_store |=> $stable(ACC))
    else $error("store moved acc");
  a_peek_store: assert property (s_store_seen ##1 s_peek_held
    |=> PEEK_DATA == $past(ACC, 2)) else $error("stored value not seen");
  a_nop_still: assert property (v && INSTR == 14'h0000 |=> $stable({ACC, ZERO_FLAG}))
    else $error("nop changed state");
  a_done_pulse: assert property (1'b1 |=> DONE == $past(v))
    else $error("done wrong");
endmodule // mox_chk
bind mox_exec mox_chk u_mox_chk (
  .CLK(CLK),
  .RSTN(RSTN),
  .INSTR_VALID(INSTR_VALID),
  .INSTR(INSTR),
  .PEEK_ADDR(PEEK_ADDR),
  .ACC(ACC),
  .ZERO_FLAG(ZERO_FLAG),
  .PEEK_DATA(PEEK_DATA),
  .DONE(DONE)
);
`default_nettype wire

// *** test/mox_exec_test.sv ***
// Self-checking bench for mox_exec; file space seen through PEEK.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/10ps
`default_nettype none
module mox_exec_test;
  reg CLK = 1'h0;
  reg RSTN = 1'h0;
  reg INSTR_VALID = 1'h0;
  reg [13:0] INSTR = 14'h0000;
  reg [6:0] PEEK_ADDR = 7'h7f;
  wire [7:0] ACC;
  wire [7:0] PEEK_DATA;
  wire ZERO_FLAG;
  wire DONE;
  integer err_total = 0;
  integer n_compared = 0;

  mox_exec u_mox_exec (
    .CLK(CLK),
    .RSTN(RSTN),
    .INSTR_VALID(INSTR_VALID),
    .INSTR(INSTR),
    .PEEK_ADDR(PEEK_ADDR),
    .ACC(ACC),
    .ZERO_FLAG(ZERO_FLAG),
    .PEEK_DATA(PEEK_DATA),
    .DONE(DONE)
  );

  initial begin
    forever begin
      #5 CLK = ~CLK;
    end
  end

  task ck(input [7:0] got, input [7:0] want, input string what);
    n_compared = n_compared + 1;
    if (got !== want) begin
      err_total = err_total + 1;
      $display("MISMATCH %0t %s got %h want %h", $time, what, got, want);
    end
  endtask

  // The word is taken at the edge after it is driven; DONE stands one cycle.
  task ex(input [13:0] word);
    @(posedge CLK);
    INSTR <= word;
    INSTR_VALID <= 1'h1;
    @(posedge CLK);
    INSTR_VALID <= 1'h0;
    #1;
    ck({7'h00, DONE}, 8'h01, "done high");
    @(posedge CLK);
    #1;
    ck({7'h00, DONE}, 8'h00, "done low");
  endtask

  task t_lit;
    ex(14'h305a);
    ck(ACC, 8'h5a, "literal acc");
    ck({7'h00, ZERO_FLAG}, 8'h00, "literal flag");
  endtask

  task t_store;
    ex(14'h00ff);
    ck(PEEK_DATA, 8'h5a, "store file");
    ck(ACC, 8'h5a, "store acc");
  endtask

  task t_move;
    ex(14'h3000);
    ex(14'h0090);
    ex(14'h0890);
    ck({7'h00, ZERO_FLAG}, 8'h01, "move back zero");
    ck(ACC, 8'h00, "move back acc");
    ex(14'h30a5);
    ck(ACC, 8'ha5, "literal acc");
    ck({7'h00, ZERO_FLAG}, 8'h01, "literal keeps flag");
    ex(14'h0091);
    ck({7'h00, ZERO_FLAG}, 8'h01, "store keeps flag");
    ex(14'h0811);
    ck(ACC, 8'ha5, "move stored");
    ck({7'h00, ZERO_FLAG}, 8'h00, "move nonzero");
    ex(14'h087f);
    ck(ACC, 8'h5a, "move to acc");
  endtask

  task t_or;
    ex(14'h3001);
    ex(14'h04ff);
    ck(PEEK_DATA, 8'h5b, "or to file");
    ck(ACC, 8'h01, "or to file acc");
    ck({7'h00, ZERO_FLAG}, 8'h00, "or nonzero");
    ex(14'h3000);
    ex(14'h0410);
    ck({7'h00, ZERO_FLAG}, 8'h01, "or zero");
    ck(ACC, 8'h00, "or zero acc");
    ex(14'h047f);
    ck(ACC, 8'h5b, "or to acc");
    ck({7'h00, ZERO_FLAG}, 8'h00, "or to acc flag");
  endtask

  task t_nop;
    ex(14'h0890);
    ex(14'h0000);
    ck(ACC, 8'h5b, "nop acc");
    ck({7'h00, ZERO_FLAG}, 8'h01, "nop flag");
    ck(PEEK_DATA, 8'h5b, "nop file");
    ex(14'h3fff);
    ck(ACC, 8'h5b, "unknown acc");
    ck({7'h00, ZERO_FLAG}, 8'h01, "unknown flag");
  endtask

  // Reset clears the outputs but leaves the file space as it was.
  task t_reset;
    @(posedge CLK);
    RSTN <= 1'h0;
    @(posedge CLK);
    #1;
    ck(ACC, 8'h00, "reset acc");
    ck({7'h00, ZERO_FLAG}, 8'h00, "reset flag");
    ck({7'h00, DONE}, 8'h00, "reset done");
    ck(PEEK_DATA, 8'h00, "reset peek");
    @(posedge CLK);
    RSTN <= 1'h1;
    @(posedge CLK);
    #1;
    ck(PEEK_DATA, 8'h5b, "file kept");
    ex(14'h3033);
    ck(ACC, 8'h33, "literal after reset");
  endtask

  task summarize;
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge CLK);
    RSTN <= 1'h1;
    t_lit;
    t_store;
    t_move;
    t_or;
    t_nop;
    t_reset;
    summarize;
  end

  // The scenarios need about 64 cycles; the limit leaves a wide margin.
  initial begin
    #3000;
    err_total = err_total + 1;
    $display("MISMATCH %0t watchdog expired", $time);
    summarize;
  end
endmodule // mox_exec_test
`default_nettype wire
